/* File: design/wdt_pkg.sv */
// Package for the windowed watchdog timer: register addresses, field positions,
// reset values, timing counts and the state encoding.
// Assumes an 8-bit special-function register port with separate read and write strobes.
package wdt_pkg;
  // Special-function register addresses.
  localparam logic [7:0] ADDR_CONTROL = 8'hbb;
  localparam logic [7:0] ADDR_RELOAD = 8'hbc;
  localparam logic [7:0] ADDR_WINDOW = 8'hbd;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hbe;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hbf;
  // Control register field positions.
  localparam int CTL_PRESCALE = 0;
  localparam int CTL_REFRESH = 1;
  localparam int CTL_ENABLE = 2;
  localparam int CTL_PREWARN = 4;
  localparam int CTL_WINDOW_EN = 5;
  // Debug suspend field position inside its register.
  localparam int SUSP_WATCHDOG = 0;
  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] SUSPEND_RESET = 8'h01;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // Prescaler divide ratios and prewarning length in counter increments.
  localparam int DIV_FAST = 2;
  localparam int DIV_SLOW = 128;
  localparam logic [7:0] PREWARN_COUNT = 8'h30;
  // Operating states, Gray coded along idle, counting, prewarning, reset.
  typedef enum logic [1:0] {
    WDT_IDLE = 2'b00,
    WDT_COUNT = 2'b01,
    WDT_PREWARN = 2'b11,
    WDT_RESET = 2'b10
  } wdt_state_t;
endpackage : wdt_pkg

/* File: design/wdt_watchdog.sv */
// Windowed watchdog timer: a 16-bit up-counter with prescaler, refresh, window check,
// prewarning phase and watchdog reset request.
// Assumes synchronous register strobes and that the system reset generator clears the block.
module wdt_watchdog (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Special-function register port.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_write,
  input wire logic sfr_read,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Debug suspend register access and processor debug status.
  input wire logic suspend_write,
  input wire logic [7:0] suspend_wdata,
  output logic [7:0] debug_suspend_control,
  input wire logic debug_mode,
  // Requests to the interrupt logic and reset generator.
  output logic watchdog_nmi_request,
  output logic watchdog_reset_signal,
  // Reset indication flag and its software clear.
  input wire logic reset_flag_clear,
  output logic watchdog_reset_flag
);

  // Byte access helpers used by several decode paths.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction

  logic [7:0] reload_byte, window_bound_byte, next_reload, next_window;
  logic prescale_select_bit, watchdog_enable_bit, window_enable_bit, refresh_request_bit;
  logic next_prescale, next_enable, next_window_en, next_refresh;
  logic [15:0] watchdog_counter, next_counter;
  logic [6:0] prescale_count, next_prescale_count;
  logic [7:0] prewarn_left, next_prewarn_left;
  wdt_pkg::wdt_state_t state, next_state;
  logic [7:0] next_rdata, next_suspend;
  logic next_nmi, next_wreset, next_flag;
  logic tick, suspended, overflow, in_window, refresh_now;

  // Register writes; the refresh bit is a one-shot handled by the counter logic.
  always_comb begin
    next_reload = reload_byte;
    next_window = window_bound_byte;
    next_prescale = prescale_select_bit;
    next_enable = watchdog_enable_bit;
    next_window_en = window_enable_bit;
    next_refresh = 1'b0; // Refresh request clears itself after one cycle.
    next_suspend = debug_suspend_control;
    if (sfr_write && hit(sfr_addr, wdt_pkg::ADDR_RELOAD)) begin
      next_reload = sfr_wdata;
    end
    if (sfr_write && hit(sfr_addr, wdt_pkg::ADDR_WINDOW)) begin
      next_window = sfr_wdata;
    end
    if (sfr_write && hit(sfr_addr, wdt_pkg::ADDR_CONTROL)) begin
      next_prescale = sfr_wdata[wdt_pkg::CTL_PRESCALE];
      next_window_en = sfr_wdata[wdt_pkg::CTL_WINDOW_EN];
      next_refresh = sfr_wdata[wdt_pkg::CTL_REFRESH];
      // Once prewarning starts the enable cannot be cleared.
      if (state != wdt_pkg::WDT_PREWARN && state != wdt_pkg::WDT_RESET) begin
        next_enable = sfr_wdata[wdt_pkg::CTL_ENABLE];
      end
    end
    if (suspend_write) begin
      next_suspend = {2'b00, suspend_wdata[5:0]}; // Bits 7:6 are reserved zeros.
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      reload_byte <= wdt_pkg::BYTE_RESET;
      window_bound_byte <= wdt_pkg::BYTE_RESET;
      prescale_select_bit <= 1'b0;
      watchdog_enable_bit <= 1'b0;
      window_enable_bit <= 1'b0;
      refresh_request_bit <= 1'b0;
      debug_suspend_control <= wdt_pkg::SUSPEND_RESET;
    end else begin
      reload_byte <= next_reload;
      window_bound_byte <= next_window;
      prescale_select_bit <= next_prescale;
      watchdog_enable_bit <= next_enable;
      window_enable_bit <= next_window_en;
      refresh_request_bit <= next_refresh;
      debug_suspend_control <= next_suspend;
    end
  end

  // Prescaler tick and the conditions derived from the count.
  // The prescaler is held clear in idle and ticks only outside idle and reset, so a fresh start always waits a full period.
  // Suspension freezes the prescaler as well, so no partial period is lost across a debug halt.
  assign suspended = debug_mode && debug_suspend_control[wdt_pkg::SUSP_WATCHDOG];
  assign tick = !suspended && state != wdt_pkg::WDT_IDLE && state != wdt_pkg::WDT_RESET &&
    (prescale_select_bit ? prescale_count == 7'(wdt_pkg::DIV_SLOW - 1)
                         : prescale_count[0] == 1'b1);
  assign overflow = tick && watchdog_counter == 16'hffff;
  // The refresh is acted on the cycle after the write, when the bit reads as one.
  assign refresh_now = refresh_request_bit && state == wdt_pkg::WDT_COUNT;
  assign in_window = window_enable_bit && watchdog_counter[15:8] < window_bound_byte;

  // Counter, prescaler and state sequencing.
  // A refresh restarts the prescaler too, so the interval after a refresh is exact to the cycle.
  // The refresh branch sits above the overflow branch, which gives the refresh the tie.
  always_comb begin
    next_state = state;
    next_counter = watchdog_counter;
    next_prescale_count = suspended ? prescale_count : prescale_count + 7'h01;
    next_prewarn_left = prewarn_left;
    next_nmi = 1'b0;
    next_wreset = watchdog_reset_signal;
    if (tick) begin
      next_prescale_count = 7'h00;
      next_counter = watchdog_counter + 16'h0001;
    end
    case (state)
      wdt_pkg::WDT_IDLE: begin
        next_prescale_count = 7'h00;
        if (watchdog_enable_bit) begin
          next_counter = {reload_byte, 8'h00};
          next_state = wdt_pkg::WDT_COUNT;
        end
      end
      wdt_pkg::WDT_COUNT: begin
        if (!watchdog_enable_bit) begin
          next_state = wdt_pkg::WDT_IDLE;
        end else if (refresh_now && in_window) begin
          next_state = wdt_pkg::WDT_RESET; // Early refresh: reset, no NMI.
          next_wreset = 1'b1;
        end else if (refresh_now) begin
          next_counter = {reload_byte, 8'h00}; // Refresh beats overflow.
          next_prescale_count = 7'h00;
        end else if (overflow) begin
          next_state = wdt_pkg::WDT_PREWARN;
          next_nmi = 1'b1;
          next_prewarn_left = wdt_pkg::PREWARN_COUNT;
        end
      end
      wdt_pkg::WDT_PREWARN: begin
        // Refreshes are not looked at here.
        if (tick) begin
          next_prewarn_left = prewarn_left - 8'h01;
          if (prewarn_left == 8'h01) begin
            next_state = wdt_pkg::WDT_RESET;
            next_wreset = 1'b1;
          end
        end
      end
      wdt_pkg::WDT_RESET: begin
        next_wreset = 1'b1; // Held until the system reset clears the block.
      end
      default: begin
        next_state = wdt_pkg::WDT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= wdt_pkg::WDT_IDLE;
      watchdog_counter <= 16'h0000;
      prescale_count <= 7'h00;
      prewarn_left <= 8'h00;
      watchdog_nmi_request <= 1'b0;
      watchdog_reset_signal <= 1'b0;
    end else begin
      state <= next_state;
      watchdog_counter <= next_counter;
      prescale_count <= next_prescale_count;
      prewarn_left <= next_prewarn_left;
      watchdog_nmi_request <= next_nmi;
      watchdog_reset_signal <= next_wreset;
    end
  end

  // The reset flag is sticky; a new watchdog reset beats a software clear.
  // It is cleared by the system reset too, whereas a real chip would clear it on a power-on reset only.
  assign next_flag = watchdog_reset_signal ? 1'b1 : (reset_flag_clear ? 1'b0 : watchdog_reset_flag);

  always_ff @(posedge clock) begin
    if (reset) begin
      watchdog_reset_flag <= 1'b0;
    end else begin
      watchdog_reset_flag <= next_flag;
    end
  end

  // Read data, registered; unmapped addresses read zero.
  always_comb begin
    next_rdata = 8'h00;
    if (sfr_read) begin
      case (sfr_addr)
        wdt_pkg::ADDR_CONTROL: begin
          next_rdata = {2'b00, window_enable_bit, state == wdt_pkg::WDT_PREWARN || state == wdt_pkg::WDT_RESET,
            1'b0, watchdog_enable_bit, refresh_request_bit, prescale_select_bit};
        end
        wdt_pkg::ADDR_RELOAD: next_rdata = reload_byte;
        wdt_pkg::ADDR_WINDOW: next_rdata = window_bound_byte;
        wdt_pkg::ADDR_COUNT_LOW: next_rdata = watchdog_counter[7:0];
        wdt_pkg::ADDR_COUNT_HIGH: next_rdata = watchdog_counter[15:8];
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sfr_rdata <= wdt_pkg::CONTROL_RESET;
    end else begin
      sfr_rdata <= next_rdata;
    end
  end

  // Checks tied to the documented behaviour.
  overflow_nmi_a: assert property (@(posedge clock) disable iff (reset)
    (state == wdt_pkg::WDT_COUNT && overflow && !refresh_now && watchdog_enable_bit)
      |=> watchdog_nmi_request && state == wdt_pkg::WDT_PREWARN)
    else $error("overflow did not raise nmi");
  refresh_wins_a: assert property (@(posedge clock) disable iff (reset)
    (state == wdt_pkg::WDT_COUNT && refresh_now && !in_window && watchdog_enable_bit)
      |=> !watchdog_nmi_request && watchdog_counter == {$past(reload_byte), 8'h00})
    else $error("refresh not applied");
  refresh_clears_a: assert property (@(posedge clock) disable iff (reset)
    refresh_request_bit |=> !refresh_request_bit || $past(sfr_write && sfr_addr == wdt_pkg::ADDR_CONTROL))
    else $error("refresh bit stuck");
  enable_held_a: assert property (@(posedge clock) disable iff (reset)
    state == wdt_pkg::WDT_PREWARN |=> watchdog_enable_bit)
    else $error("disabled during prewarning");
  window_reset_a: assert property (@(posedge clock) disable iff (reset)
    (state == wdt_pkg::WDT_COUNT && refresh_now && in_window && watchdog_enable_bit)
      |=> watchdog_reset_signal && !watchdog_nmi_request)
    else $error("early refresh did not reset");
  reset_sticky_a: assert property (@(posedge clock) disable iff (reset)
    watchdog_reset_signal |=> watchdog_reset_flag && watchdog_reset_signal)
    else $error("reset flag not set");
  idle_still_a: assert property (@(posedge clock) disable iff (reset)
    (state == wdt_pkg::WDT_IDLE && !watchdog_enable_bit) |=> $stable(watchdog_counter))
    else $error("counting while disabled");
  suspend_hold_a: assert property (@(posedge clock) disable iff (reset)
    (suspended && state == wdt_pkg::WDT_COUNT && !refresh_now) |=> $stable(watchdog_counter))
    else $error("counting while suspended");
  fast_tick_a: assert property (@(posedge clock) disable iff (reset)
    tick && !prescale_select_bit |-> !$past(tick))
    else $error("fast prescale too fast");
  prewarn_end_a: assert property (@(posedge clock) disable iff (reset)
    (state == wdt_pkg::WDT_PREWARN && tick && prewarn_left == 8'h01) |=> watchdog_reset_signal)
    else $error("prewarning did not end in reset");
  // A single-cycle pulse, so the interrupt logic sees each error exactly once.
  nmi_pulse_a: assert property (@(posedge clock) disable iff (reset)
    watchdog_nmi_request |=> !watchdog_nmi_request)
    else $error("nmi request longer than one cycle");
  // Enabling must start from the programmed value, not from a stale count.
  enable_load_a: assert property (@(posedge clock) disable iff (reset)
    (state == wdt_pkg::WDT_IDLE && watchdog_enable_bit)
      |=> state == wdt_pkg::WDT_COUNT && watchdog_counter == {$past(reload_byte), 8'h00})
    else $error("enable did not load start value");
  // Nothing but the reset state may follow the prewarning phase.
  prewarn_locked_a: assert property (@(posedge clock) disable iff (reset)
    state == wdt_pkg::WDT_PREWARN |=> state == wdt_pkg::WDT_PREWARN || state == wdt_pkg::WDT_RESET)
    else $error("prewarning left without reset");
  reset_held_a: assert property (@(posedge clock) disable iff (reset)
    state == wdt_pkg::WDT_RESET |-> watchdog_reset_signal)
    else $error("reset request dropped");
  overflow_wrap_a: assert property (@(posedge clock) disable iff (reset)
    (state == wdt_pkg::WDT_COUNT && overflow && !refresh_now) |=> watchdog_counter == 16'h0000)
    else $error("overflow did not wrap to zero");
  // The count registers show the count as it stood at the read edge.
  count_read_a: assert property (@(posedge clock) disable iff (reset)
    (sfr_read && sfr_addr == wdt_pkg::ADDR_COUNT_HIGH) |=> sfr_rdata == $past(watchdog_counter[15:8]))
    else $error("count high read wrong");

  refresh_seen_c: cover property (@(posedge clock) refresh_now && !in_window);
  prewarn_seen_c: cover property (@(posedge clock) state == wdt_pkg::WDT_PREWARN);
  window_hit_c: cover property (@(posedge clock) refresh_now && in_window);
  tie_case_c: cover property (@(posedge clock) refresh_now && overflow);
  // Counting on while the processor is halted needs the suspend bit cleared first.
  debug_run_c: cover property (@(posedge clock) debug_mode && !suspended && tick);

endmodule // wdt_watchdog

/* File: tb/wdt_sys_model.sv */
// Model of the interrupt logic and reset generator that face the watchdog.
// Assumes the watchdog requests are registered on the rising clock edge.
module wdt_sys_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Requests from the watchdog.
  input wire logic nmi,
  input wire logic sys_reset,
  // What the system has seen.
  output int nmi_count,
  output logic reset_taken
);
  timeunit 1ns;
  timeprecision 1ps;
  // Every high cycle counts, so a stretched pulse shows up as extra requests.
  always @(posedge clock) begin
    if (reset) begin
      nmi_count <= 0;
      reset_taken <= 1'b0;
    end else begin
      if (nmi === 1'b1) nmi_count <= nmi_count + 1;
      if (sys_reset === 1'b1) reset_taken <= 1'b1;
    end
  end
endmodule // wdt_sys_model

/* File: tb/wdt_watchdog_tb.sv */
// Self-checking bench for the windowed watchdog timer.
// Assumes the design package is compiled first and a 100 MHz clock.
module wdt_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0;
  logic reset = 1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, suspend_wdata = 8'h00, sfr_rdata, debug_suspend_control, rd, rel;
  logic sfr_write = 0, sfr_read = 0, suspend_write = 0, debug_mode = 0, reset_flag_clear = 0;
  logic watchdog_nmi_request, watchdog_reset_signal, watchdog_reset_flag, reset_taken;
  int nmi_count, mismatches = 0, checked = 0, cycles = 0, n, per, t0, dummy;
  always #5 clock = ~clock;
  wdt_watchdog DUT (.clock(clock), .reset(reset), .sfr_addr(sfr_addr), .sfr_write(sfr_write),
    .sfr_read(sfr_read), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .suspend_write(suspend_write),
    .suspend_wdata(suspend_wdata), .debug_suspend_control(debug_suspend_control), .debug_mode(debug_mode),
    .watchdog_nmi_request(watchdog_nmi_request), .watchdog_reset_signal(watchdog_reset_signal),
    .reset_flag_clear(reset_flag_clear), .watchdog_reset_flag(watchdog_reset_flag));
  wdt_sys_model sys (.clock(clock), .reset(reset), .nmi(watchdog_nmi_request),
    .sys_reset(watchdog_reset_signal), .nmi_count(nmi_count), .reset_taken(reset_taken));
  // The run is cut short well past the longest expected sequence.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic do_reset();
    @(posedge clock);
    reset <= 1'b1;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
  endtask
  // A write is taken at the edge after the strobe goes up.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_write <= 1'b1;
    @(posedge clock);
    sfr_write <= 1'b0;
  endtask
  // Read data is registered, so it is picked up just after the taking edge.
  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_read <= 1'b1;
    @(posedge clock);
    sfr_read <= 1'b0;
    #1 d = sfr_rdata;
  endtask
  // Samples the pre-edge value each cycle, so a one-cycle pulse is never missed.
  task automatic wait_hi(input bit which, input int limit, output int k);
    k = 0;
    while ((which ? watchdog_reset_signal : watchdog_nmi_request) !== 1'b1 && k < limit) begin
      @(posedge clock);
      k++;
    end
  endtask
  function automatic int period(input int p, input int r);
    return (p ? wdt_pkg::DIV_SLOW : wdt_pkg::DIV_FAST) * (65536 - r * 256);
  endfunction
  initial begin
    dummy = $urandom(48);
    do_reset();
    // Reset state, idle counter, map and access kinds.
    rdr(wdt_pkg::ADDR_CONTROL, rd);
    check("control reset", rd, wdt_pkg::CONTROL_RESET);
    check("suspend reset", debug_suspend_control, wdt_pkg::SUSPEND_RESET);
    wr(wdt_pkg::ADDR_COUNT_HIGH, 8'h55);
    repeat (20) @(posedge clock);
    rdr(wdt_pkg::ADDR_COUNT_HIGH, rd);
    check("idle count", rd, 8'h00);
    rdr(8'hba, rd);
    check("unmapped", rd, 8'h00);
    rel = 8'($urandom);
    wr(wdt_pkg::ADDR_RELOAD, rel);
    wr(wdt_pkg::ADDR_WINDOW, ~rel);
    rdr(wdt_pkg::ADDR_RELOAD, rd);
    check("reload", rd, rel);
    rdr(wdt_pkg::ADDR_WINDOW, rd);
    check("window", rd, 8'(~rel));
    // Debug freezes the count until the suspend bit is cleared.
    wr(wdt_pkg::ADDR_RELOAD, 8'h00);
    debug_mode <= 1'b1;
    wr(wdt_pkg::ADDR_CONTROL, 8'h04);
    repeat (40) @(posedge clock);
    rdr(wdt_pkg::ADDR_COUNT_LOW, rd);
    check("suspended", rd, 8'h00);
    @(posedge clock);
    suspend_wdata <= 8'hc0;
    suspend_write <= 1'b1;
    @(posedge clock);
    suspend_write <= 1'b0;
    @(posedge clock);
    check("suspend cleared", debug_suspend_control, 8'h00);
    repeat (39) @(posedge clock);
    rdr(wdt_pkg::ADDR_COUNT_LOW, rd);
    check("running in debug", 16'(rd >= 8'd18 && rd <= 8'd24), 16'h1);
    debug_mode <= 1'b0;
    // Overflow, prewarning and the final reset, for both prescaler settings.
    for (int p = 0; p < 2; p++) begin
      do_reset();
      rel = p ? 8'hff : {4'hf, 4'($urandom)};
      wr(wdt_pkg::ADDR_RELOAD, rel);
      wr(wdt_pkg::ADDR_CONTROL, 8'(4 + p));
      rdr(wdt_pkg::ADDR_COUNT_HIGH, rd);
      check("start high", rd, rel);
      wr(wdt_pkg::ADDR_CONTROL, 8'(4 + p));
      wr(wdt_pkg::ADDR_CONTROL, 8'(6 + p));
      per = period(p, int'(rel));
      wait_hi(1'b0, per + 50, n);
      t0 = cycles;
      check("overflow time", 16'(n >= per && n <= per + 8), 16'h1);
      rdr(wdt_pkg::ADDR_CONTROL, rd);
      check("prewarn control", rd, 8'(8'h14 + p));
      wr(wdt_pkg::ADDR_CONTROL, 8'(2 + p));
      repeat (2) @(posedge clock);
      rdr(wdt_pkg::ADDR_CONTROL, rd);
      check("disable refused", rd, 8'(8'h14 + p));
      rdr(wdt_pkg::ADDR_COUNT_HIGH, rd);
      check("refresh ignored", rd, 8'h00);
      check("no early reset", watchdog_reset_signal, 1'b0);
      per = 48 * (p ? wdt_pkg::DIV_SLOW : wdt_pkg::DIV_FAST);
      wait_hi(1'b1, per + 200, n);
      n = cycles - t0;
      check("prewarn length", 16'(n >= per - 2 && n <= per + 136), 16'h1);
      repeat (2) @(posedge clock);
      check("reset flag", watchdog_reset_flag, 1'b1);
      // A software clear while the reset request stands must lose to the set.
      reset_flag_clear <= 1'b1;
      @(posedge clock);
      reset_flag_clear <= 1'b0;
      @(posedge clock);
      check("flag kept", watchdog_reset_flag, 1'b1);
      check("reset taken", reset_taken, 1'b1);
      check("one nmi", 16'(nmi_count), 16'h1);
    end
    // Timely refreshes keep the count away from overflow.
    do_reset();
    wr(wdt_pkg::ADDR_RELOAD, 8'hfe);
    wr(wdt_pkg::ADDR_CONTROL, 8'h04);
    repeat (4) begin
      repeat (300 + $urandom % 600) @(posedge clock);
      wr(wdt_pkg::ADDR_CONTROL, 8'h04);
      wr(wdt_pkg::ADDR_CONTROL, 8'h06);
      rdr(wdt_pkg::ADDR_COUNT_HIGH, rd);
      check("refreshed high", rd, 8'hfe);
    end
    // A refresh acted on in the very cycle of the overflow tick must win.
    // Reload 0xff gives 256 ticks of two cycles; the second refresh lands on the last one.
    wr(wdt_pkg::ADDR_RELOAD, 8'hff);
    wr(wdt_pkg::ADDR_CONTROL, 8'h06);
    repeat (510) @(posedge clock);
    wr(wdt_pkg::ADDR_CONTROL, 8'h06);
    rdr(wdt_pkg::ADDR_COUNT_HIGH, rd);
    check("tie refresh", rd, 8'hff);
    check("no nmi", 16'(nmi_count), 16'h0);
    // Window: a late refresh is accepted, an early one resets at once.
    do_reset();
    wr(wdt_pkg::ADDR_RELOAD, 8'hf0);
    wr(wdt_pkg::ADDR_WINDOW, 8'hf8);
    wr(wdt_pkg::ADDR_CONTROL, 8'h24);
    repeat (4200) @(posedge clock);
    wr(wdt_pkg::ADDR_CONTROL, 8'h26);
    repeat (5) @(posedge clock);
    check("late refresh", watchdog_reset_signal, 1'b0);
    wr(wdt_pkg::ADDR_CONTROL, 8'h26);
    wait_hi(1'b1, 10, n);
    check("early refresh", 16'(n <= 3), 16'h1);
    check("window no nmi", 16'(nmi_count), 16'h0);
    tally_and_finish();
  end
endmodule // wdt_watchdog_tb
